// [rtl/cfl_pkg.sv]
// Purpose: shared constants for the condition flag logic
// Assumes: 8-bit core, flags register of eight bits
// Notes:   bit positions, reset value and operation codes live here only
`default_nettype none

// ==================================================
// package
package cfl_pkg;
	// flag bit positions
	localparam int unsigned FLG_V_POS = 7;
	localparam int unsigned FLG_B6_POS = 6;
	localparam int unsigned FLG_B5_POS = 5;
	localparam int unsigned FLG_H_POS = 4;
	localparam int unsigned FLG_I_POS = 3;
	localparam int unsigned FLG_N_POS = 2;
	localparam int unsigned FLG_Z_POS = 1;
	localparam int unsigned FLG_C_POS = 0;
	// reset value: mask set, fixed bits 6 and 5 high, other flags clear
	localparam logic [7:0] FLG_RESET = 8'h68;
	// fixed pattern for bits 6 and 5
	localparam logic [1:0] FLG_FIXED = 2'h3;
	// register index of the flag register on the plain port
	localparam logic [3:0] REG_FLAGS_ADDR = 4'h0;
	localparam logic [3:0] REG_STATUS_ADDR = 4'h1;

	// operation codes presented by the sequencer
	typedef enum logic [3:0] {
		CFL_OP_NONE    = 4'h0,
		CFL_OP_ADD     = 4'h1,
		CFL_OP_ADC     = 4'h2,
		CFL_OP_SUB     = 4'h3,
		CFL_OP_SBC     = 4'h4,
		CFL_OP_LOGIC   = 4'h5,
		CFL_OP_MOVE8   = 4'h6,
		CFL_OP_MOVE16  = 4'h7,
		CFL_OP_SHIFT   = 4'h8,
		CFL_OP_BITTEST = 4'h9,
		CFL_OP_DAA     = 4'hA,
		CFL_OP_CLI     = 4'hB,
		CFL_OP_SEI     = 4'hC,
		CFL_OP_TAP     = 4'hD,
		CFL_OP_ARITH16 = 4'hE
	} cfl_op_t;

	// interrupt entry sequence states
	typedef enum logic [1:0] {
		CFL_IRQ_IDLE  = 2'b00,
		CFL_IRQ_STACK = 2'b01,
		CFL_IRQ_MASK  = 2'b10,
		CFL_IRQ_FETCH = 2'b11
	} cfl_irq_state_t;
endpackage : cfl_pkg

`default_nettype wire

// [rtl/cfl_arith.sv]
// Purpose: combinational add and subtract with flag outputs
// Assumes: operands of WIDTH bits, carry input from the carry flag
// Notes:   half-carry is taken from bit 3 into bit 4
`default_nettype none

// ==================================================
// arithmetic unit
module cfl_arith #(
	parameter int unsigned WIDTH = 8
) (
	// operands
	input  wire logic [WIDTH-1:0] op_a,
	input  wire logic [WIDTH-1:0] op_b,
	input  wire logic             carry_in,
	input  wire logic             subtract,
	// results
	output logic      [WIDTH-1:0] sum,
	output logic                  carry_out,
	output logic                  half_carry,
	output logic                  overflow
);
	logic [WIDTH:0]   full_w;
	logic [WIDTH-1:0] b_eff;
	logic [4:0]       low_w;

	// refused at elaboration: the half-carry tap needs bits 3 and 4
	if (WIDTH < 8) begin : g_width_check
		$error("cfl_arith needs WIDTH of at least 8");
	end

	// subtract is add of the complement; borrow is inverted carry
	always_comb begin
		b_eff = subtract ? ~op_b : op_b;
		full_w = {1'b0, op_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, subtract ^ carry_in};
		low_w = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, subtract ^ carry_in};
		sum = full_w[WIDTH-1:0];
		carry_out = full_w[WIDTH] ^ subtract;
		half_carry = low_w[4];
		overflow = (op_a[WIDTH-1] == b_eff[WIDTH-1]) && (sum[WIDTH-1] != op_a[WIDTH-1]);
	end
endmodule : cfl_arith

`default_nettype wire

// [rtl/cfl_decadj.sv]
// Purpose: decimal adjust correction after a packed decimal add
// Assumes: value is the result of a preceding add
// Notes:   correction uses half-carry and carry flags
`default_nettype none

// ==================================================
// decimal adjust
module cfl_decadj (
	// inputs
	input  wire logic [7:0] value,
	input  wire logic       half_in,
	input  wire logic       carry_in,
	// outputs
	output logic      [7:0] adjusted,
	output logic            carry_out
);
	logic [7:0] corr;
	logic [8:0] sum_w;

	// low nibble fixed when above nine or half-carry; high when value above 99 hex or carry
	always_comb begin
		corr = 8'h00;
		if (half_in || (value[3:0] > 4'h9)) begin
			corr[3:0] = 4'h6;
		end
		carry_out = carry_in || (value > 8'h99);
		if (carry_out) begin
			corr[7:4] = 4'h6;
		end
		sum_w = {1'b0, value} + {1'b0, corr};
		adjusted = sum_w[7:0];
	end
endmodule : cfl_decadj

`default_nettype wire

// [rtl/cfl_top.sv]
// Purpose: condition flag logic of an 8-bit core
// Assumes: sequencer presents one operation per exec_valid pulse
// Notes:   flags register also reachable over a plain register port
// Operation
// RULE1 - overflow flag bit 7 tracks signed overflow for affecting operations
// RULE2 - half-carry set on carry from bit 3 into bit 4 on adds
// RULE3 - decimal adjust corrects prior add result using half-carry and carry
// RULE4 - mask bit 3 set blocks maskable interrupts, clear accepts them
// RULE5 - interrupt entry: stack registers, then set mask, then fetch handler
// RULE6 - no interrupt taken at boundary right after mask clearing instruction
// RULE7 - negative flag bit 2 follows result bit 7
// RULE8 - plain load or store sets negative to moved value msb
// RULE9 - zero flag bit 1 set when result is all zero
// RULE10 - plain load or store sets zero when moved value is zero
// RULE11 - carry flag bit 0 set on carry out of bit 7
// RULE12 - carry acts as borrow on subtraction
// RULE13 - bit test, shift and rotate also write carry
// RULE14 - unaffected flags hold; bits 6 and 5 read constant
//
// Strobed register access and the register offsets were chosen for this implementation.
`default_nettype none

// ==================================================
// top
module cfl_top
	import cfl_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// execute port from the sequencer
	input  wire logic        exec_valid,
	input  wire cfl_pkg::cfl_op_t exec_op,
	input  wire logic [15:0] opnd_a,
	input  wire logic [7:0]  opnd_b,
	input  wire logic        shift_carry,
	input  wire logic [7:0]  tap_value,
	// instruction boundary and interrupts
	input  wire logic        boundary,
	input  wire logic        irq_req,
	input  wire logic        stack_done,
	// results to datapath
	output logic [7:0]       result_q,
	output logic             irq_take,
	output logic             stack_start,
	output logic             fetch_vector,
	// flags to branch logic
	output logic [7:0]       flags_out,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata
);
	logic [7:0]     flags_q;
	logic [7:0]     flags_d;
	logic [7:0]     result_d;
	logic           shadow_q;
	cfl_irq_state_t irq_state_q;
	logic [7:0]     ar_sum;
	logic           ar_c;
	logic           ar_h;
	logic           ar_v;
	logic           ar_sub;
	logic           ar_cin;
	logic [7:0]     da_val;
	logic           da_c;
	logic           mask_clearing;
	logic           set_mask;

	// ==================================================
	// arithmetic and decimal adjust
	assign ar_sub = (exec_op == CFL_OP_SUB) || (exec_op == CFL_OP_SBC);
	assign ar_cin = ((exec_op == CFL_OP_ADC) || (exec_op == CFL_OP_SBC)) ? flags_q[FLG_C_POS] : 1'b0;

	cfl_arith #(
		.WIDTH      (8)
	) u_arith (
		.op_a       (opnd_a[7:0]),
		.op_b       (opnd_b),
		.carry_in   (ar_cin),
		.subtract   (ar_sub),
		.sum        (ar_sum),
		.carry_out  (ar_c),
		.half_carry (ar_h),
		.overflow   (ar_v)
	);

	cfl_decadj u_decadj (
		.value     (opnd_a[7:0]),
		.half_in   (flags_q[FLG_H_POS]),
		.carry_in  (flags_q[FLG_C_POS]),
		.adjusted  (da_val),
		.carry_out (da_c)
	);

	// zero test used by several operations
	function automatic logic is_zero8(input logic [7:0] v);
		return v == 8'h00;
	endfunction : is_zero8

	// ==================================================
	// next flag value
	// each case writes only the flags its operation affects; others hold
	always_comb begin
		flags_d = flags_q; // see RULE14
		result_d = result_q;
		set_mask = 1'b0;
		mask_clearing = 1'b0;
		if (exec_valid) begin
			case (exec_op)
				CFL_OP_ADD, CFL_OP_ADC: begin
					result_d = ar_sum;
					flags_d[FLG_V_POS] = ar_v; // see RULE1
					flags_d[FLG_H_POS] = ar_h; // see RULE2
					flags_d[FLG_N_POS] = ar_sum[7]; // see RULE7
					flags_d[FLG_Z_POS] = is_zero8(ar_sum); // see RULE9
					flags_d[FLG_C_POS] = ar_c; // see RULE11
				end
				CFL_OP_SUB, CFL_OP_SBC: begin
					result_d = ar_sum;
					flags_d[FLG_V_POS] = ar_v; // see RULE1
					flags_d[FLG_N_POS] = ar_sum[7]; // see RULE7
					flags_d[FLG_Z_POS] = is_zero8(ar_sum); // see RULE9
					flags_d[FLG_C_POS] = ar_c; // see RULE12
				end
				CFL_OP_LOGIC: begin
					result_d = opnd_a[7:0];
					flags_d[FLG_V_POS] = 1'b0; // see RULE1
					flags_d[FLG_N_POS] = opnd_a[7]; // see RULE7
					flags_d[FLG_Z_POS] = is_zero8(opnd_a[7:0]); // see RULE9
				end
				CFL_OP_MOVE8: begin
					result_d = opnd_a[7:0];
					flags_d[FLG_V_POS] = 1'b0;
					flags_d[FLG_N_POS] = opnd_a[7]; // see RULE8
					flags_d[FLG_Z_POS] = is_zero8(opnd_a[7:0]); // see RULE10
				end
				CFL_OP_MOVE16: begin
					result_d = opnd_a[7:0];
					flags_d[FLG_V_POS] = 1'b0;
					flags_d[FLG_N_POS] = opnd_a[15]; // see RULE8
					flags_d[FLG_Z_POS] = opnd_a == 16'h0000; // see RULE10
				end
				CFL_OP_ARITH16: begin
					// 16-bit result computed by the datapath, flags derived here
					result_d = opnd_a[7:0];
					flags_d[FLG_N_POS] = opnd_a[15]; // see RULE7
					flags_d[FLG_Z_POS] = opnd_a == 16'h0000; // see RULE9
				end
				CFL_OP_SHIFT: begin
					result_d = opnd_a[7:0];
					flags_d[FLG_N_POS] = opnd_a[7]; // see RULE7
					flags_d[FLG_Z_POS] = is_zero8(opnd_a[7:0]); // see RULE9
					flags_d[FLG_C_POS] = shift_carry; // see RULE13
					flags_d[FLG_V_POS] = opnd_a[7] ^ shift_carry; // see RULE1
				end
				CFL_OP_BITTEST: begin
					flags_d[FLG_C_POS] = shift_carry; // see RULE13
				end
				CFL_OP_DAA: begin
					result_d = da_val; // see RULE3
					flags_d[FLG_C_POS] = da_c; // see RULE3
					flags_d[FLG_N_POS] = da_val[7]; // see RULE7
					flags_d[FLG_Z_POS] = is_zero8(da_val); // see RULE9
				end
				CFL_OP_CLI: begin
					flags_d[FLG_I_POS] = 1'b0;
					mask_clearing = 1'b1;
				end
				CFL_OP_SEI: begin
					flags_d[FLG_I_POS] = 1'b1;
				end
				CFL_OP_TAP: begin
					flags_d = tap_value;
					mask_clearing = ~tap_value[FLG_I_POS];
				end
				default: begin
					flags_d = flags_q;
				end
			endcase
		end
		// software write wins over a concurrent operation
		if (reg_wr && (reg_addr == REG_FLAGS_ADDR)) begin
			flags_d = reg_wdata;
			mask_clearing = ~reg_wdata[FLG_I_POS];
		end
		// interrupt entry sets the mask after stacking
		if (irq_state_q == CFL_IRQ_MASK) begin
			flags_d[FLG_I_POS] = 1'b1; // see RULE5
			set_mask = 1'b1;
		end
		flags_d[FLG_B6_POS:FLG_B5_POS] = FLG_FIXED; // see RULE14
	end

	// ==================================================
	// flag and result registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags_q <= FLG_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_q <= 8'h00;
		end else begin
			result_q <= result_d;
		end
	end

	// ==================================================
	// interrupt shadow
	// held from a mask-clearing instruction until the next boundary has passed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shadow_q <= 1'b0;
		end else if (mask_clearing && flags_q[FLG_I_POS]) begin
			shadow_q <= 1'b1; // see RULE6
		end else if (boundary) begin
			shadow_q <= 1'b0;
		end
	end

	// accepted only at a boundary, mask clear, no shadow, sequence idle
	assign irq_take = boundary && irq_req && !flags_q[FLG_I_POS] && !shadow_q
		&& (irq_state_q == CFL_IRQ_IDLE); // see RULE4

	// ==================================================
	// interrupt entry sequence
	// the mask is set only after stacking so the stacked copy keeps the old mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_state_q <= CFL_IRQ_IDLE;
		end else begin
			case (irq_state_q)
				CFL_IRQ_IDLE: begin
					if (irq_take) begin
						irq_state_q <= CFL_IRQ_STACK; // see RULE5
					end
				end
				CFL_IRQ_STACK: begin
					if (stack_done) begin
						irq_state_q <= CFL_IRQ_MASK;
					end
				end
				CFL_IRQ_MASK: begin
					irq_state_q <= CFL_IRQ_FETCH;
				end
				CFL_IRQ_FETCH: begin
					irq_state_q <= CFL_IRQ_IDLE;
				end
				default: begin
					irq_state_q <= CFL_IRQ_IDLE;
				end
			endcase
		end
	end

	assign stack_start = (irq_state_q == CFL_IRQ_STACK);
	assign fetch_vector = (irq_state_q == CFL_IRQ_FETCH); // see RULE5
	assign flags_out = flags_q;

	// ==================================================
	// register read port: data one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_FLAGS_ADDR: reg_rdata <= flags_q;
				REG_STATUS_ADDR: reg_rdata <= {5'h00, shadow_q, irq_state_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// set_mask kept for clarity of the entry step
	logic unused_ok;
	assign unused_ok = set_mask;
endmodule : cfl_top

`default_nettype wire

// [testbench/cfl_top_asserts.sv]
// Purpose: concurrent checks on the flag logic ports
// Assumes: one clock, synchronous active high reset
// Notes:   bound to cfl_top at the foot of this file
`default_nettype none

// ====================
// checker
module cfl_top_asserts
	import cfl_pkg::*;
(
	// clock and reset
	input wire logic             ref_clk,
	input wire logic             rst,
	// execute and handshake inputs
	input wire logic             exec_valid,
	input wire cfl_pkg::cfl_op_t exec_op,
	input wire logic [15:0]      opnd_a,
	input wire logic [7:0]       opnd_b,
	input wire logic             reg_wr,
	input wire logic             stack_done,
	// outputs watched
	input wire logic             irq_take,
	input wire logic             stack_start,
	input wire logic             fetch_vector,
	input wire logic [7:0]       flags_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic       ex;
	logic [8:0] s9;
	logic [4:0] h5;
	// a register write wins over the op, so only clean ops are judged
	assign ex = exec_valid && !reg_wr;
	assign s9 = {1'h0, opnd_a[7:0]} + {1'h0, opnd_b};
	assign h5 = {1'h0, opnd_a[3:0]} + {1'h0, opnd_b[3:0]};
	property p_fixed; flags_out[6:5] == FLG_FIXED; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed bits moved");
	property p_mask; flags_out[3] |-> !irq_take; endproperty
	a_mask: assert property (p_mask) else $error("taken while masked");
	property p_entry; irq_take |=> stack_start; endproperty
	a_entry: assert property (p_entry) else $error("no push after take");
	property p_fetch; fetch_vector |-> flags_out[3] && !stack_start; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch before mask");
	property p_done; stack_start && stack_done |-> ##[1:4] fetch_vector; endproperty
	a_done: assert property (p_done) else $error("no fetch after push");
	property p_add; ex && exec_op == CFL_OP_ADD |=> {flags_out[4], flags_out[0]} == $past({h5[4], s9[8]}); endproperty
	a_add: assert property (p_add) else $error("add carries wrong");
	property p_vadd;
		ex && exec_op == CFL_OP_ADD |=> flags_out[7] == $past(opnd_a[7] == opnd_b[7] && s9[7] != opnd_a[7]);
	endproperty
	a_vadd: assert property (p_vadd) else $error("add overflow wrong");
	property p_sub; ex && exec_op == CFL_OP_SUB |=> flags_out[0] == $past(opnd_a[7:0] < opnd_b); endproperty
	a_sub: assert property (p_sub) else $error("borrow wrong");
	property p_mv8; ex && exec_op == CFL_OP_MOVE8 |=> flags_out[2:1] == $past({opnd_a[7], opnd_a[7:0] == 8'h00}); endproperty
	a_mv8: assert property (p_mv8) else $error("byte move flags wrong");
	property p_mv16; ex && exec_op == CFL_OP_MOVE16 |=> flags_out[2:1] == $past({opnd_a[15], opnd_a == 16'h0000}); endproperty
	a_mv16: assert property (p_mv16) else $error("word move flags wrong");
	property p_shadow; ex && exec_op == CFL_OP_CLI && flags_out[3] |=> !irq_take; endproperty
	a_shadow: assert property (p_shadow) else $error("taken in shadow");
endmodule : cfl_top_asserts

bind cfl_top cfl_top_asserts i_cfl_top_asserts (.ref_clk, .rst, .exec_valid, .exec_op, .opnd_a, .opnd_b,
	.reg_wr, .stack_done, .irq_take, .stack_start, .fetch_vector, .flags_out);

`default_nettype wire

// [testbench/cfl_stack_model.sv]
// Purpose: sequencer side model that pushes registers on request
// Assumes: stack_start holds until stack_done is seen
// Notes:   slow stretches the push to eight cycles
`default_nettype none

// ====================
// stack push model
module cfl_stack_model (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// pace select
	input  wire logic slow,
	// push handshake
	input  wire logic stack_start,
	output var  logic stack_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	// answer once per request; a dropped request restarts the count
	always_ff @(posedge ref_clk) begin
		if (rst || !stack_start || stack_done) begin
			cnt_q      <= 4'h0;
			stack_done <= 1'h0;
		end else begin
			cnt_q      <= cnt_q + 4'h1;
			stack_done <= (cnt_q == (slow ? 4'h7 : 4'h0));
		end
	end
endmodule : cfl_stack_model

`default_nettype wire

// [testbench/cfl_top_tb.sv]
// Purpose: self-checking bench for the flag logic
// Assumes: 25 MHz clock, sync reset held three cycles
// Notes:   only mismatches and the verdict are printed
`default_nettype none

// ====================
// bench
module cfl_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cfl_pkg::*;
	logic        ref_clk = 1'h0, rst = 1'h1, exec_valid = 1'h0, shift_carry = 1'h0, slow = 1'h0;
	logic        boundary = 1'h0, irq_req = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic        stack_done, irq_take, stack_start, fetch_vector;
	cfl_op_t     exec_op = CFL_OP_NONE;
	logic [15:0] opnd_a = 16'h0000;
	logic [7:0]  opnd_b = 8'h00, reg_wdata = 8'h00, result_q, flags_out, reg_rdata;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  tap_value = 8'h00;
	int          mismatches = 0, tests_run = 0;
	// tap source driven so the flag transfer op is exercised too
	cfl_top i_cfl_top (.ref_clk, .rst, .exec_valid, .exec_op, .opnd_a, .opnd_b, .shift_carry, .tap_value,
		.boundary, .irq_req, .stack_done, .result_q, .irq_take, .stack_start, .fetch_vector, .flags_out,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	cfl_stack_model i_cfl_stack_model (.ref_clk, .rst, .slow, .stack_start, .stack_done);
	// 40 ns period
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic conclude;
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// one op; shift carry rides on operand b bit 0
	task automatic ex(input cfl_op_t o, input logic [15:0] a, input logic [7:0] b);
		@(posedge ref_clk);
		exec_valid  <= 1'h1;
		exec_op     <= o;
		opnd_a      <= a;
		opnd_b      <= b;
		shift_carry <= b[0];
		@(posedge ref_clk);
		exec_valid <= 1'h0;
		#1;
	endtask : ex
	task automatic ar(input cfl_op_t o, input logic [15:0] a, input logic [7:0] b, r, f, m);
		ex(o, a, b);
		if (o < CFL_OP_LOGIC)
			chk(result_q, r);
		chk(flags_out & m, f & m);
	endtask : ar
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, e);
	endtask : rdc
	// boundary with a pending request; irq_take judged in that cycle
	task automatic bnd(input logic e);
		@(posedge ref_clk);
		boundary <= 1'h1;
		irq_req  <= 1'h1;
		#1 chk(irq_take, e);
		@(posedge ref_clk);
		boundary <= 1'h0;
		irq_req  <= 1'h0;
	endtask : bnd
	task automatic t_regs;
		rdc(REG_FLAGS_ADDR, FLG_RESET);
		wr(REG_FLAGS_ADDR, 8'h00);
		rdc(REG_FLAGS_ADDR, 8'h60);
		rdc(REG_STATUS_ADDR, 8'h04);
		wr(REG_FLAGS_ADDR, 8'hFF);
		wr(4'h5, 8'h00);
		rdc(4'h5, 8'h00);
		rdc(REG_FLAGS_ADDR, 8'hFF);
		wr(REG_FLAGS_ADDR, 8'h68);
	endtask : t_regs
	// half-carry after subtract is left open, so masked there
	task automatic t_arith;
		ar(CFL_OP_ADD, 16'h007F, 8'h01, 8'h80, 8'hFC, 8'hFF);
		ar(CFL_OP_ADD, 16'h00FF, 8'h01, 8'h00, 8'h7B, 8'hFF);
		ar(CFL_OP_ADC, 16'h000E, 8'h01, 8'h10, 8'h78, 8'hFF);
		ar(CFL_OP_SUB, 16'h0080, 8'h01, 8'h7F, 8'hE8, 8'hEF);
		ar(CFL_OP_SUB, 16'h0000, 8'h01, 8'hFF, 8'h6D, 8'hEF);
		ar(CFL_OP_SBC, 16'h0005, 8'h05, 8'hFF, 8'h6D, 8'hEF);
		ar(CFL_OP_LOGIC, 16'h0000, 8'h00, 8'h00, 8'h6B, 8'hEF);
		ar(CFL_OP_MOVE8, 16'h0080, 8'h00, 8'h00, 8'h6D, 8'hEF);
		ar(CFL_OP_MOVE16, 16'h0100, 8'h00, 8'h00, 8'h69, 8'hEF);
		ar(CFL_OP_MOVE16, 16'h0000, 8'h00, 8'h00, 8'h6B, 8'hEF);
		ar(CFL_OP_MOVE16, 16'h8000, 8'h00, 8'h00, 8'h6D, 8'hEF);
		ar(CFL_OP_SHIFT, 16'h0000, 8'h01, 8'h00, 8'h01, 8'h01);
		ar(CFL_OP_SHIFT, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h01);
		ar(CFL_OP_BITTEST, 16'h0000, 8'h01, 8'h00, 8'h01, 8'h01);
		ar(CFL_OP_BITTEST, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h01);
		tap_value <= 8'h9F;
		ar(CFL_OP_TAP, 16'h0000, 8'h00, 8'h00, 8'hFF, 8'hFF);
		ar(CFL_OP_ARITH16, 16'h0000, 8'h00, 8'h00, 8'hFB, 8'hFF);
		ar(CFL_OP_ARITH16, 16'h8001, 8'h00, 8'h00, 8'hFD, 8'hFF);
		tap_value <= 8'h00;
		ar(CFL_OP_TAP, 16'h0000, 8'h00, 8'h00, 8'h60, 8'hFF);
		ar(CFL_OP_SEI, 16'h0000, 8'h00, 8'h00, 8'h68, 8'hFF);
	endtask : t_arith
	task automatic dj(input logic [7:0] a, b, r, input logic c);
		ex(CFL_OP_ADD, {8'h00, a}, b);
		ex(CFL_OP_DAA, {8'h00, a + b}, 8'h00);
		chk(result_q, r);
		chk(flags_out[0], c);
	endtask : dj
	task automatic t_daa;
		dj(8'h09, 8'h09, 8'h18, 1'h0);
		dj(8'h99, 8'h01, 8'h00, 1'h1);
		dj(8'h15, 8'h27, 8'h42, 1'h0);
	endtask : t_daa
	// slow push first, then prompt; mask cleared by op, then by write
	task automatic t_irq;
		int n;
		for (int s = 1; s >= 0; s--) begin
			slow <= s[0];
			bnd(1'h0);
			if (s == 1)
				ex(CFL_OP_CLI, 16'h0000, 8'h00);
			else
				wr(REG_FLAGS_ADDR, 8'h60);
			bnd(1'h0);
			bnd(1'h1);
			#1 chk(stack_start, 1'h1);
			n = 0;
			while (fetch_vector !== 1'h1 && n < 40) begin
				@(posedge ref_clk);
				#1 n++;
			end
			chk(fetch_vector, 1'h1);
			chk(flags_out[3], 1'h1);
		end
	endtask : t_irq
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		t_regs;
		t_arith;
		t_daa;
		t_irq;
		conclude;
	end
	// hang guard, far beyond the hundred or so cycles needed
	initial begin
		#100000;
		mismatches++;
		conclude;
	end
endmodule : cfl_top_tb

`default_nettype wire
